// >>> include/dcd_pkg.sv
// Package for the command decoder: command codes, bursts, decoded command word.
// Assumes a single 100 MHz clock domain in the consumer.
package dcd_pkg;

	localparam int BA_W = 3;
	localparam int ADDR_W = 16;
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;
	localparam int COL_W = 10;
	localparam int ROW_W = 16;
	localparam logic [3:0] BL8_BEATS = 4'h8;
	localparam logic [3:0] BL4_BEATS = 4'h4;
	localparam logic [3:0] BURST_CLKS_BL8 = 4'h4;
	localparam logic [3:0] BURST_CLKS_BL4 = 4'h2;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [BA_W-1:0] BANK_RST = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

	typedef enum logic [3:0] {
		DCD_CMD_NONE,
		DCD_CMD_MRS,
		DCD_CMD_REF,
		DCD_CMD_SRE,
		DCD_CMD_SRX,
		DCD_CMD_PRE,
		DCD_CMD_ACT,
		DCD_CMD_WR,
		DCD_CMD_RD,
		DCD_CMD_ZQ,
		DCD_CMD_PDE,
		DCD_CMD_PDX,
		DCD_CMD_RSVD
	} dcd_cmd_t;

	typedef enum logic [1:0] {
		DCD_ST_IDLE,
		DCD_ST_PWRDN,
		DCD_ST_SELFREF
	} dcd_pwr_t;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
		logic odt;
		logic [BA_W-1:0] ba;
		logic [ADDR_W-1:0] addr;
	} dcd_pins_t;

	typedef struct packed {
		dcd_cmd_t cmd;
		logic [BA_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic auto_pre;
		logic chop4;
	} dcd_dec_t;

endpackage

// >>> rtl/dcd_sync.sv
// Two-stage synchroniser for a bundle of pin levels.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module dcd_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_reg <= '0;
			q_o <= '0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/dcd_decoder.sv
// Command decoder for a DDR3-style memory device.
// Assumes pins arrive asynchronously and are synchronised here; one clock.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RULE1: Commands come from CS, RAS, CAS, WE and CKE sampled on rising edge.
// RULE2: All strobes low, CKE high twice: mode register set, bank picks register.
// RULE3: Bank lines choose the bank; activate opens the row on address.
// RULE4: Write is CS, CAS, WE low, RAS high; A10 low means no precharge.
// RULE5: On-the-fly write: A12 low chops to four, high gives eight.
// RULE6: Write with A10 high precharges its bank after the burst.
// RULE7: Read is CS, CAS low, RAS, WE high; column from low address.
// RULE8: On-the-fly read: A12 high gives eight, low chops to four.
// RULE9: Read with A10 high auto precharges; A12 still picks length.
// RULE10: Bursts always complete; fixed or on-the-fly set by mode register.
// RULE11: Controller keeps the active-low reset high in normal operation.
// RULE12: Valid inputs must be driven to defined levels by the controller.
// RULE13: No refresh happens during power-down; controller keeps refresh intervals.
// RULE14: Termination input never affects decoding; unavailable in self-refresh.
// RULE15: Self-refresh exit is seen on CKE rising with NOP or deselect.
// RULE16: NOP registers nothing and leaves running bursts alone.
// RULE17: Controller issues NOP when idle or waiting.
// RULE18: Chip select high ignores everything else, acting as NOP.
// RULE19: CKE fall with refresh enters self-refresh, with NOP enters power-down; code enters power-down instead while a burst runs.
// RULE20: Controller enters self-refresh only with all banks idle.
// RULE21: After self-refresh exit controller sends only NOP or deselect.
// RULE22: Unlisted encodings are reserved and change no state.
module dcd_decoder (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic cke_i,
	input wire logic odt_i,
	input wire logic [dcd_pkg::BA_W-1:0] ba_i,
	input wire logic [dcd_pkg::ADDR_W-1:0] addr_i,
	input wire logic otf_mode_i,
	output logic cmd_valid_o,
	output dcd_pkg::dcd_cmd_t cmd_o,
	output logic [dcd_pkg::BA_W-1:0] bank_o,
	output logic [dcd_pkg::ADDR_W-1:0] addr_o,
	output logic auto_pre_o,
	output logic chop4_o,
	output logic burst_busy_o,
	output logic [3:0] burst_beats_o,
	output logic precharge_o,
	output logic [dcd_pkg::BA_W-1:0] precharge_bank_o,
	output logic pwrdn_o,
	output logic selfref_o,
	output logic odt_en_o
);
	localparam int PIN_W = $bits(dcd_pkg::dcd_pins_t);

	dcd_pkg::dcd_pins_t pins_raw;
	dcd_pkg::dcd_pins_t pins;
	dcd_pkg::dcd_dec_t dec;
	dcd_pkg::dcd_pwr_t pwr_reg;
	logic cke_prev_reg;
	logic [3:0] burst_cnt_reg;
	logic ap_pend_reg;
	logic [dcd_pkg::BA_W-1:0] ap_bank_reg;

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	assign pins_raw = '{cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i,
		cke: cke_i, odt: odt_i, ba: ba_i, addr: addr_i};

	dcd_sync #(
		.WIDTH(PIN_W)
	) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i(pins_raw),
		.q_o(pins)
	);

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	function automatic dcd_pkg::dcd_dec_t decode(input dcd_pkg::dcd_pins_t p, input logic ckep,
		input logic otf);
		dcd_pkg::dcd_dec_t d;
		logic nop_like;
		d.cmd = dcd_pkg::DCD_CMD_NONE;
		d.bank = p.ba; // RULE3
		d.addr = p.addr;
		d.auto_pre = p.addr[dcd_pkg::AP_BIT];
		d.chop4 = otf & ~p.addr[dcd_pkg::BC_BIT];
		nop_like = p.cs_n | (p.ras_n & p.cas_n & p.we_n); // RULE18
		if (ckep && p.cke) begin
			if (p.cs_n) begin
				d.cmd = dcd_pkg::DCD_CMD_NONE; // RULE18
			end else begin
				unique case ({p.ras_n, p.cas_n, p.we_n}) // RULE1
					3'b000: d.cmd = dcd_pkg::DCD_CMD_MRS; // RULE2
					3'b001: d.cmd = dcd_pkg::DCD_CMD_REF;
					3'b010: d.cmd = dcd_pkg::DCD_CMD_PRE;
					3'b011: d.cmd = dcd_pkg::DCD_CMD_ACT; // RULE3
					3'b100: d.cmd = dcd_pkg::DCD_CMD_WR; // RULE4
					3'b101: d.cmd = dcd_pkg::DCD_CMD_RD; // RULE7
					3'b110: d.cmd = dcd_pkg::DCD_CMD_ZQ;
					3'b111: d.cmd = dcd_pkg::DCD_CMD_NONE; // RULE16
				endcase
			end
		end else if (ckep && !p.cke) begin
			if (!p.cs_n && !p.ras_n && !p.cas_n && p.we_n) begin
				d.cmd = dcd_pkg::DCD_CMD_SRE; // RULE19
			end else if (nop_like) begin
				d.cmd = dcd_pkg::DCD_CMD_PDE; // RULE19
			end else begin
				d.cmd = dcd_pkg::DCD_CMD_RSVD; // RULE22
			end
		end else if (!ckep && p.cke) begin
			d.cmd = nop_like ? dcd_pkg::DCD_CMD_PDX : dcd_pkg::DCD_CMD_RSVD; // RULE19
		end
		return d;
	endfunction

	always_comb begin
		dec = decode(pins, cke_prev_reg, otf_mode_i); // RULE14
		if (dec.cmd == dcd_pkg::DCD_CMD_PDX && pwr_reg == dcd_pkg::DCD_ST_SELFREF) begin
			dec.cmd = dcd_pkg::DCD_CMD_SRX; // RULE15
		end
		if (dec.cmd == dcd_pkg::DCD_CMD_PDX && pwr_reg != dcd_pkg::DCD_ST_PWRDN) begin
			dec.cmd = dcd_pkg::DCD_CMD_RSVD; // RULE22
		end
		if (dec.cmd == dcd_pkg::DCD_CMD_SRE && burst_busy_o) begin
			dec.cmd = dcd_pkg::DCD_CMD_PDE;
		end
	end

	// ------------------------------------------------------------
	// Command output
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cke_prev_reg <= 1'b0;
		end else begin
			cke_prev_reg <= pins.cke; // RULE1
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cmd_valid_o <= 1'b0;
			cmd_o <= dcd_pkg::DCD_CMD_NONE;
			bank_o <= dcd_pkg::BANK_RST;
			addr_o <= dcd_pkg::ADDR_RST;
			auto_pre_o <= 1'b0;
			chop4_o <= 1'b0;
		end else begin
			cmd_valid_o <= dec.cmd != dcd_pkg::DCD_CMD_NONE && dec.cmd != dcd_pkg::DCD_CMD_RSVD;
			cmd_o <= dec.cmd;
			if (dec.cmd != dcd_pkg::DCD_CMD_NONE && dec.cmd != dcd_pkg::DCD_CMD_RSVD) begin
				bank_o <= dec.bank; // RULE2
				if (dec.cmd == dcd_pkg::DCD_CMD_RD || dec.cmd == dcd_pkg::DCD_CMD_WR) begin
					addr_o <= {{(dcd_pkg::ADDR_W-dcd_pkg::COL_W){1'b0}},
						dec.addr[dcd_pkg::COL_W-1:0]}; // RULE7
					auto_pre_o <= dec.auto_pre; // RULE6 RULE9
					chop4_o <= dec.chop4; // RULE5 RULE8
				end else begin
					addr_o <= dec.addr; // RULE3
					auto_pre_o <= 1'b0;
					chop4_o <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Burst tracking and auto precharge
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			burst_cnt_reg <= dcd_pkg::CNT_RST;
			burst_busy_o <= 1'b0;
			burst_beats_o <= dcd_pkg::CNT_RST;
			ap_pend_reg <= 1'b0;
			ap_bank_reg <= dcd_pkg::BANK_RST;
		end else if ((dec.cmd == dcd_pkg::DCD_CMD_RD || dec.cmd == dcd_pkg::DCD_CMD_WR)
			&& !burst_busy_o) begin
			burst_cnt_reg <= dec.chop4 ? dcd_pkg::BURST_CLKS_BL4 : dcd_pkg::BURST_CLKS_BL8;
			burst_beats_o <= dec.chop4 ? dcd_pkg::BL4_BEATS : dcd_pkg::BL8_BEATS; // RULE5 RULE8
			burst_busy_o <= 1'b1;
			ap_pend_reg <= dec.auto_pre; // RULE6 RULE9
			ap_bank_reg <= dec.bank;
		end else if (burst_cnt_reg != dcd_pkg::CNT_RST) begin
			burst_cnt_reg <= burst_cnt_reg - 4'h1; // RULE10 RULE16
			burst_busy_o <= burst_cnt_reg != 4'h1;
		end else begin
			burst_busy_o <= 1'b0;
			ap_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			precharge_o <= 1'b0;
			precharge_bank_o <= dcd_pkg::BANK_RST;
		end else begin
			precharge_o <= ap_pend_reg && burst_cnt_reg == 4'h1; // RULE6 RULE9
			precharge_bank_o <= ap_bank_reg;
		end
	end

	// ------------------------------------------------------------
	// Power state
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pwr_reg <= dcd_pkg::DCD_ST_IDLE;
		end else begin
			unique case (pwr_reg)
				dcd_pkg::DCD_ST_IDLE: begin
					if (dec.cmd == dcd_pkg::DCD_CMD_SRE) begin
						pwr_reg <= dcd_pkg::DCD_ST_SELFREF; // RULE19
					end else if (dec.cmd == dcd_pkg::DCD_CMD_PDE) begin
						pwr_reg <= dcd_pkg::DCD_ST_PWRDN; // RULE19 RULE13
					end
				end
				dcd_pkg::DCD_ST_PWRDN: begin
					if (dec.cmd == dcd_pkg::DCD_CMD_PDX) begin
						pwr_reg <= dcd_pkg::DCD_ST_IDLE; // RULE19
					end
				end
				dcd_pkg::DCD_ST_SELFREF: begin
					if (dec.cmd == dcd_pkg::DCD_CMD_SRX) begin
						pwr_reg <= dcd_pkg::DCD_ST_IDLE; // RULE15
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pwrdn_o <= 1'b0;
			selfref_o <= 1'b0;
			odt_en_o <= 1'b0;
		end else begin
			pwrdn_o <= pwr_reg == dcd_pkg::DCD_ST_PWRDN;
			selfref_o <= pwr_reg == dcd_pkg::DCD_ST_SELFREF;
			odt_en_o <= pins.odt && pwr_reg != dcd_pkg::DCD_ST_SELFREF; // RULE14
		end
	end
endmodule
`default_nettype wire

// >>> test/dcd_chk_sva.sv
// Checker: decode, burst and power timing of the command decoder.
// Assumes three clocks from pins to decoded outputs.
`timescale 1ns/1ns
`default_nettype none
module dcd_chk (
	input wire logic clk_i, sys_rst_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, cke_i, odt_i,
	input wire logic otf_mode_i, cmd_valid_o, auto_pre_o, chop4_o, burst_busy_o,
	input wire logic precharge_o, pwrdn_o, selfref_o, odt_en_o,
	input wire logic [2:0] ba_i, bank_o, precharge_bank_o,
	input wire logic [15:0] addr_i, addr_o,
	input wire logic [3:0] burst_beats_o,
	input wire dcd_pkg::dcd_cmd_t cmd_o
);
	logic [2:0] up;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			up <= 3'h0;
		else if (up != 3'h7)
			up <= up + 3'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_cmd(r, c, w);
		up == 3'h7 && $past(cke_i, 3) && $past(cke_i, 4) && !$past(cs_n_i, 3)
			&& $past({ras_n_i, cas_n_i, we_n_i}, 3) == {r, c, w};
	endsequence
	sequence s_fall(r, c, w);
		up == 3'h7 && $past(cke_i, 5) && !$past(cke_i, 4) && !$past(cs_n_i, 4)
			&& $past({ras_n_i, cas_n_i, we_n_i}, 4) == {r, c, w};
	endsequence
	sequence s_idle;
		up == 3'h7 && $past(cke_i, 3) && $past(cke_i, 4)
			&& ($past(cs_n_i, 3) || $past({ras_n_i, cas_n_i, we_n_i}, 3) == 3'h7);
	endsequence
	mrs_decode_a: assert property (s_cmd(1'b0, 1'b0, 1'b0) |-> cmd_valid_o
		&& cmd_o == dcd_pkg::DCD_CMD_MRS && bank_o == $past(ba_i, 3)) else $error("mrs decode");
	wr_decode_a: assert property (s_cmd(1'b1, 1'b0, 1'b0) |->
		cmd_o == dcd_pkg::DCD_CMD_WR && auto_pre_o == $past(addr_i[10], 3))
		else $error("write decode");
	rd_decode_a: assert property (s_cmd(1'b1, 1'b0, 1'b1) |->
		cmd_o == dcd_pkg::DCD_CMD_RD && addr_o == {6'h0, $past(addr_i[9:0], 3)}
		&& auto_pre_o == $past(addr_i[10], 3)) else $error("read decode");
	burst_chop_a: assert property (
		s_cmd(1'b1, 1'b0, 1'b1) or s_cmd(1'b1, 1'b0, 1'b0) |->
		chop4_o == ($past(otf_mode_i, 3) && !$past(addr_i[12], 3))) else $error("chop");
	nop_quiet_a: assert property (s_idle |-> !cmd_valid_o)
		else $error("nop registered");
	bl8_run_a: assert property ($rose(burst_busy_o) && burst_beats_o == 4'h8 |->
		burst_busy_o[*4] ##1 !burst_busy_o) else $error("burst length");
	bl4_run_a: assert property ($rose(burst_busy_o) && burst_beats_o == 4'h4 |->
		burst_busy_o[*2] ##1 !burst_busy_o) else $error("chopped burst length");
	beat_count_a: assert property ($rose(burst_busy_o) |->
		burst_beats_o == (chop4_o ? 4'h4 : 4'h8)) else $error("beat count");
	auto_pre_a: assert property (
		$rose(burst_busy_o) && auto_pre_o && burst_beats_o == 4'h8 |->
		!precharge_o[*4] ##1 (precharge_o && precharge_bank_o == bank_o))
		else $error("precharge");
	pre_chop_a: assert property (
		$rose(burst_busy_o) && auto_pre_o && burst_beats_o == 4'h4 |->
		!precharge_o[*2] ##1 (precharge_o && precharge_bank_o == bank_o))
		else $error("chopped precharge");
	no_pre_a: assert property ($rose(burst_busy_o) && !auto_pre_o |->
		!precharge_o[*3]) else $error("unrequested precharge");
	pwr_down_a: assert property (s_fall(1'b1, 1'b1, 1'b1) |-> ##[0:2] pwrdn_o)
		else $error("pde");
	self_ref_a: assert property (s_fall(1'b0, 1'b0, 1'b1) |-> ##[0:2] selfref_o)
		else $error("sre");
	rsvd_hold_a: assert property (s_fall(1'b0, 1'b1, 1'b1) |-> !pwrdn_o && !selfref_o)
		else $error("reserved changed state");
	odt_gate_a: assert property (selfref_o && $past(selfref_o) |-> !odt_en_o) else $error("odt");
endmodule
bind dcd_decoder dcd_chk dcd_chk_inst (.*);
`default_nettype wire

// >>> test/dcd_ctrl_model.sv
// Controller model: one command per call, then NOP with clock enable held.
// Assumes the testbench calls issue from its own process.
`timescale 1ns/1ns
`default_nettype none
module dcd_ctrl_model (
	input wire logic clk_i,
	output var dcd_pkg::dcd_pins_t pins_o
);
	initial pins_o = {1'b0, 3'h7, 1'b1, 1'b0, 3'h0, 16'h0000};
	task automatic issue(dcd_pkg::dcd_pins_t p);
		@(negedge clk_i);
		pins_o = p;
		@(negedge clk_i);
		pins_o = {1'b0, 3'h7, p.cke, p.odt, ~p.ba, ~p.addr};
	endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Testbench: commands through the controller model, decoded words scored.
// Assumes decoder latency and burst lengths of the hand-over.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk_i, sys_rst_i, otf_mode_i, cmd_valid_o, auto_pre_o, chop4_o, burst_busy_o;
	logic precharge_o, pwrdn_o, selfref_o, odt_en_o, odt_req;
	logic [1:0] apbc;
	logic [2:0] bank_o, precharge_bank_o;
	logic [15:0] addr_o;
	logic [3:0] burst_beats_o;
	dcd_pkg::dcd_cmd_t cmd_o, rw_cmd;
	dcd_pkg::dcd_pins_t pins, p;
	dcd_pkg::dcd_dec_t got_dec;
	dcd_pkg::dcd_dec_t exp_q[$];
	bit full_q[$];
	int n_mismatch, compares;
	dcd_ctrl_model ctrl_inst (.clk_i(clk_i), .pins_o(pins));
	dcd_decoder dcd_decoder_inst (.cs_n_i(pins.cs_n), .ras_n_i(pins.ras_n), .cas_n_i(pins.cas_n),
		.we_n_i(pins.we_n), .cke_i(pins.cke), .odt_i(pins.odt), .ba_i(pins.ba), .addr_i(pins.addr), .*);
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic summarize;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_dec(dcd_pkg::dcd_dec_t got, exp, bit full);
		compares++;
		if (full ? got !== exp : got.cmd !== exp.cmd) begin
			n_mismatch++;
			$display("[ERR] %0t decode %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_lvl(logic got, exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t level %b exp %b", $time, got, exp);
		end
	endtask
	task automatic go(logic [2:0] rcw, logic k, dcd_pkg::dcd_cmd_t cm, bit full, int gap);
		p = {1'b0, rcw, k, odt_req, 3'($urandom), 16'($urandom)};
		p.addr[12] = apbc[1];
		p.addr[10] = apbc[0];
		exp_q.push_back({cm, p.ba, rcw[2:1] == 2'h2 ? {6'h0, p.addr[9:0]} : p.addr,
			rcw[2:1] == 2'h2 && apbc[0], rcw[2:1] == 2'h2 && otf_mode_i && !apbc[1]});
		full_q.push_back(full);
		ctrl_inst.issue(p);
		repeat (gap) @(negedge clk_i);
	endtask
	always @(negedge clk_i) begin
		got_dec = {cmd_o, bank_o, addr_o, auto_pre_o, chop4_o};
		if (cmd_valid_o === 1'b1 && exp_q.size() == 0)
			chk_lvl(1'b1, 1'b0);
		else if (cmd_valid_o === 1'b1)
			chk_dec(got_dec, exp_q.pop_front(), full_q.pop_front());
	end
	initial begin
		#20000;
		n_mismatch++;
		$display("[ERR] %0t timeout", $time);
		summarize();
	end
	initial begin
		void'($urandom(91185));
		sys_rst_i = 1'b1;
		otf_mode_i = 1'b0;
		odt_req = 1'b0;
		apbc = 2'h0;
		repeat (8) @(negedge clk_i);
		sys_rst_i = 1'b0;
		repeat (6) @(negedge clk_i);
		go(3'h0, 1'b1, dcd_pkg::DCD_CMD_MRS, 1'b1, 2);
		go(3'h1, 1'b1, dcd_pkg::DCD_CMD_REF, 1'b0, 2);
		go(3'h3, 1'b1, dcd_pkg::DCD_CMD_ACT, 1'b1, 2);
		go(3'h2, 1'b1, dcd_pkg::DCD_CMD_PRE, 1'b0, 2);
		go(3'h6, 1'b1, dcd_pkg::DCD_CMD_ZQ, 1'b0, 2);
		$display("test basic done");
		for (int i = 0; i < 16; i++) begin
			otf_mode_i = i[3];
			apbc = i[2:1];
			rw_cmd = i[0] ? dcd_pkg::DCD_CMD_RD : dcd_pkg::DCD_CMD_WR;
			go({2'h2, i[0]}, 1'b1, rw_cmd, 1'b1, 6);
		end
		apbc = 2'h2;
		go(3'h5, 1'b1, dcd_pkg::DCD_CMD_RD, 1'b1, 0);
		go(3'h4, 1'b1, dcd_pkg::DCD_CMD_WR, 1'b1, 8);
		$display("test bursts done");
		for (int i = 0; i < 12; i++) begin
			p = 25'($urandom);
			p.cke = 1'b1;
			if (!p.cs_n)
				{p.ras_n, p.cas_n, p.we_n} = 3'h7;
			ctrl_inst.issue(p);
		end
		ctrl_inst.issue({1'b0, 3'h3, 1'b0, 1'b0, 3'h0, 16'h0000});
		repeat (4) @(negedge clk_i);
		chk_lvl(pwrdn_o, 1'b0);
		chk_lvl(selfref_o, 1'b0);
		ctrl_inst.issue({1'b0, 3'h7, 1'b1, 1'b0, 3'h0, 16'h0000});
		repeat (4) @(negedge clk_i);
		chk_lvl(pwrdn_o, 1'b0);
		$display("test idle done");
		go(3'h7, 1'b0, dcd_pkg::DCD_CMD_PDE, 1'b0, 6);
		chk_lvl(pwrdn_o, 1'b1);
		go(3'h7, 1'b1, dcd_pkg::DCD_CMD_PDX, 1'b0, 6);
		chk_lvl(pwrdn_o, 1'b0);
		odt_req = 1'b1;
		go(3'h1, 1'b0, dcd_pkg::DCD_CMD_SRE, 1'b0, 8);
		chk_lvl(selfref_o, 1'b1);
		chk_lvl(odt_en_o, 1'b0);
		go(3'h7, 1'b1, dcd_pkg::DCD_CMD_SRX, 1'b0, 8);
		chk_lvl(selfref_o, 1'b0);
		chk_lvl(odt_en_o, 1'b1);
		chk_lvl(exp_q.size() == 0, 1'b1);
		$display("test power done");
		summarize();
	end
endmodule
`default_nettype wire
